// File: hdl/ddr_burst2_common_io_sram_port.sv
// Burst-of-two common-I/O SRAM port, the memory end of the link.
// Assumes link_clk from the controller; one link cycle is one data beat, k_edge marks K beats.
// Storage is flip-flops cleared by reset; the narrow build hides the burst LSB from the pins.
//
// Summary of operation
// [R1] Every read or write moves two beats
// [R2] A started burst always completes
// [R3] Back-to-back loads every K cycle accepted
// [R4] Deselect pipelined like read; reads finish first
// [R5] Load high ignores command, deselects after bursts
// [R6] Read captured at K: load low, rw high
// [R7] First read beat at next K-bar/C-bar beat
// [R8] Second read beat on following K/C beat
// [R9] Controller gives first write beat next K
// [R10] Second write beat captured on K-bar
// [R11] Lane enables sampled with each data beat
// [R12] High enable leaves its lane unchanged
// [R13] Lanes masked independently on each beat
// [R14] Loaded address is base of two beats
// [R15] Narrow variant uses two 4-bit nybble enables
// [R16] Output clocks held high: launch from K
// [R17] Controller may delay output clocks slightly
// [R18] Low loop-disable input turns loop off
// [R19] Cycle counter periodically triggers impedance check
// [R20] Impedance moves one binary step per check
// [R21] Hidden burst LSB starts zero, then one
// [R22] Second enable covers upper lane bits
// [R23] Controller inserts deselect between read and write
`timescale 1ns/1ps
module ddr_burst2_common_io_sram_port
  import burst2_sram_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int LANES = LANES_DEF,
  parameter int LANE_W = LANE_W_DEF,
  parameter bit LSB_PIN = 1'b1,
  parameter int IMP_PERIOD = IMP_PERIOD_DEF
) (
  input wire logic reset_n,
  burst2_sram_link.device_end lnk,
  input wire logic out_clk_tied,
  input wire logic dll_disable_n,
  input wire logic imp_compare_up,
  output logic dll_enabled,
  output logic launch_from_k,
  output logic [IMP_CODE_W-1:0] imp_code
);

  // ************************************************************
  // Types and state
  // ************************************************************
  localparam int DATA_W = LANES * LANE_W;
  // [R21] Narrow parts hide the burst LSB, so storage has one more index bit
  localparam int IDX_W = LSB_PIN ? ADDR_W : ADDR_W + 1;
  localparam int DEPTH = 1 << IDX_W;
  localparam int CNT_W = $clog2(IMP_PERIOD);
  localparam logic [IMP_CODE_W-1:0] IMP_MAX = '1;
  localparam logic [IMP_CODE_W-1:0] IMP_MIN = '0;

  typedef struct packed {
    op_e op;
    logic [IDX_W-1:0] idx;
  } slot_s;

  typedef struct packed {
    slot_s [DEV_PIPE_DEPTH-1:0] pipe;
    logic [DEPTH-1:0][DATA_W-1:0] mem;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe;
    logic [1:0] dll_sync;
    logic [1:0] tied_sync;
    logic [1:0] cmp_sync;
    logic [CNT_W-1:0] imp_cnt;
    logic [IMP_CODE_W-1:0] imp_code;
  } state_s;

  state_s s_ff;
  state_s nxt_s;

  // ************************************************************
  // Decode helpers
  // ************************************************************
  // [R14] Burst word index from the loaded base and the beat number
  function automatic logic [IDX_W-1:0] beat_idx(input logic [IDX_W-1:0] base, input logic second);
    logic [IDX_W-1:0] r;
    r = base;
    r[0] = LSB_PIN ? (base[0] ^ second) : second;
    return r;
  endfunction : beat_idx

  // Slot decode, shared by the write and the read beat logic
  function automatic logic slot_is(input slot_s slot, input op_e op);
    return slot.op == op;
  endfunction : slot_is

  // [R10] Pipe age at which write beat b sits on the bus
  function automatic int wr_age(input int b);
    return (b == 0) ? WR_BEAT1_AGE : WR_BEAT2_AGE;
  endfunction : wr_age

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic [IDX_W-1:0] wr_idx;
    logic [IDX_W-1:0] cap_idx;
    wr_idx = '0;
    cap_idx = '0;
    nxt_s = s_ff;

    // Pins from the board, not from the link
    nxt_s.dll_sync = {s_ff.dll_sync[0], dll_disable_n};
    nxt_s.tied_sync = {s_ff.tied_sync[0], out_clk_tied};
    nxt_s.cmp_sync = {s_ff.cmp_sync[0], imp_compare_up};

    // [R4] Deselects enter the same pipe as reads, as empty slots
    nxt_s.pipe[DEV_PIPE_DEPTH-1:1] = s_ff.pipe[DEV_PIPE_DEPTH-2:0];
    nxt_s.pipe[0].op = OP_NOP;
    nxt_s.pipe[0].idx = '0;
    // [R3] A new command may be taken on every K beat
    if (lnk.k_edge && !lnk.load_command_n) begin
      if (LSB_PIN) begin
        cap_idx = IDX_W'(lnk.sync_address_inputs);
      end else begin
        // [R21] Hidden LSB: base takes a zero below the address
        cap_idx = IDX_W'({lnk.sync_address_inputs, 1'b0});
      end
      // [R6] Read when rw high, write when low
      nxt_s.pipe[0].op = lnk.read_write ? OP_READ : OP_WRITE;
      nxt_s.pipe[0].idx = cap_idx;
    end
    // [R5] Load high leaves the new slot empty; older bursts still run

    // [R10] Write beats: first on the next K, second on the K-bar after it
    for (int b = 0; b < BEATS; b++) begin
      if (slot_is(s_ff.pipe[wr_age(b)], OP_WRITE)) begin
        wr_idx = beat_idx(s_ff.pipe[wr_age(b)].idx, b[0]);
        // [R11] Lane enables sampled on the same edge as the beat
        for (int l = 0; l < LANES; l++) begin
          // [R12] Lane stored only when its enable is low
          // [R13] Each lane and beat decided on its own
          // [R22] Enable l guards lane l, so the second covers the upper bits
          // [R15] A lane width of 4 gives nybble lanes, same timing
          if (!lnk.byte_write_enable_n[l]) begin
            nxt_s.mem[wr_idx][l*LANE_W +: LANE_W] = lnk.dq[l*LANE_W +: LANE_W];
          end
        end
      end
    end

    // ************************************************************
    // Read beats
    // ************************************************************
    // Reads see the array before this edge's write lands, so old data wins
    // [R1] Exactly two read beats per read, no way to cut them short
    nxt_s.dq_oe = 1'b0;
    nxt_s.dq_out = s_ff.dq_out;
    // [R7] First read beat launched at the K-bar beat
    if (slot_is(s_ff.pipe[RD_BEAT1_AGE], OP_READ)) begin
      nxt_s.dq_out = s_ff.mem[beat_idx(s_ff.pipe[RD_BEAT1_AGE].idx, 1'b0)];
      nxt_s.dq_oe = 1'b1;
    end
    // [R8] Second read beat on the following K beat
    if (slot_is(s_ff.pipe[RD_BEAT2_AGE], OP_READ)) begin
      nxt_s.dq_out = s_ff.mem[beat_idx(s_ff.pipe[RD_BEAT2_AGE].idx, 1'b1)];
      nxt_s.dq_oe = 1'b1;
    end

    // ************************************************************
    // Impedance stepping
    // ************************************************************
    // [R19] Period counter restarts after each impedance check
    if (s_ff.imp_cnt == CNT_W'(IMP_PERIOD - 1)) begin
      nxt_s.imp_cnt = '0;
      // [R20] At most one step toward the comparator's side
      if (s_ff.cmp_sync[1] && s_ff.imp_code != IMP_MAX) begin
        nxt_s.imp_code = s_ff.imp_code + IMP_CODE_W'(1);
      end else if (!s_ff.cmp_sync[1] && s_ff.imp_code != IMP_MIN) begin
        nxt_s.imp_code = s_ff.imp_code - IMP_CODE_W'(1);
      end
    end else begin
      nxt_s.imp_cnt = s_ff.imp_cnt + CNT_W'(1);
    end
  end

  // ************************************************************
  // State register on the link clock
  // ************************************************************
  // [R2] Only reset_n clears the pipe, so a started burst always ends
  always_ff @(posedge lnk.link_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign lnk.dq_dev_o = s_ff.dq_out;
  assign lnk.dq_dev_oe = s_ff.dq_oe;
  // [R18] Loop runs only while the disable pin is high
  assign dll_enabled = s_ff.dll_sync[1];
  // [R16] Tied output clocks hand launch timing to K and K-bar
  assign launch_from_k = s_ff.tied_sync[1];
  assign imp_code = s_ff.imp_code;

endmodule : ddr_burst2_common_io_sram_port

// File: hdl/burst2_sram_pkg.sv
// Shared constants and types for the burst-of-two common-I/O SRAM link.
// Assumes one link beat per link clock cycle, K and K-bar beats alternating.
package burst2_sram_pkg;

  // ************************************************************
  // Link geometry defaults
  // ************************************************************
  localparam int ADDR_W_DEF = 4;
  localparam int LANES_DEF = 2;
  localparam int LANE_W_DEF = 9;
  localparam int BEATS = 2;

  // ************************************************************
  // Device pipeline ages, in link beats after the command edge
  // ************************************************************
  localparam int WR_BEAT1_AGE = 1;
  localparam int WR_BEAT2_AGE = 2;
  localparam int RD_BEAT1_AGE = 2;
  localparam int RD_BEAT2_AGE = 3;
  localparam int DEV_PIPE_DEPTH = 4;

  // ************************************************************
  // Host pipeline ages, in host ticks after the command tick
  // ************************************************************
  localparam int HOST_WR1_AGE = 1;
  localparam int HOST_WR2_AGE = 2;
  localparam int HOST_RD1_AGE = 3;
  localparam int HOST_RD2_AGE = 4;
  localparam int HOST_PIPE_DEPTH = 5;

  // ************************************************************
  // Output impedance stepping
  // ************************************************************
  localparam int IMP_CODE_W = 5;
  localparam int IMP_PERIOD_DEF = 1024;

  typedef enum logic [1:0] {OP_NOP, OP_READ, OP_WRITE} op_e;

endpackage : burst2_sram_pkg

// File: hdl/burst2_sram_link.sv
// Pin-level link between the memory controller and the SRAM port.
// Assumes the controller end makes link_clk; the dq wire is resolved here from the two enables.
`timescale 1ns/1ps
interface burst2_sram_link #(
  parameter int ADDR_W = 4,
  parameter int LANES = 2,
  parameter int LANE_W = 9
);
  localparam int DATA_W = LANES * LANE_W;

  logic link_clk;
  logic k_edge;
  logic load_command_n;
  logic read_write;
  logic [ADDR_W-1:0] sync_address_inputs;
  logic [LANES-1:0] byte_write_enable_n;
  logic [DATA_W-1:0] dq_host_o;
  logic dq_host_oe;
  logic [DATA_W-1:0] dq_dev_o;
  logic dq_dev_oe;
  logic [DATA_W-1:0] dq;

  // Undriven bus reads as zero; contention shows device data
  assign dq = dq_dev_oe ? dq_dev_o : (dq_host_oe ? dq_host_o : '0);

  modport device_end (
    input link_clk, k_edge, load_command_n, read_write, sync_address_inputs, byte_write_enable_n, dq,
    output dq_dev_o, dq_dev_oe
  );
  modport host_end (
    output link_clk, k_edge, load_command_n, read_write, sync_address_inputs, byte_write_enable_n,
    output dq_host_o, dq_host_oe,
    input dq
  );
endinterface : burst2_sram_link

// File: hdl/burst2_sram_controller.sv
// Memory controller end of the burst-of-two SRAM link.
// Assumes sys_clk; link_clk is sys_clk divided by two and driven out, so the link is no second domain here.
`timescale 1ns/1ps
module burst2_sram_controller
  import burst2_sram_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int LANES = LANES_DEF,
  parameter int LANE_W = LANE_W_DEF
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  burst2_sram_link.host_end lnk,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [BEATS*LANES*LANE_W-1:0] req_wdata,
  input wire logic [BEATS*LANES-1:0] req_mask_n,
  output logic rd_valid,
  output logic [BEATS*LANES*LANE_W-1:0] rd_data
);

  // ************************************************************
  // Types and state
  // ************************************************************
  localparam int DATA_W = LANES * LANE_W;

  typedef struct packed {
    op_e op;
    logic [BEATS*DATA_W-1:0] wdata;
    logic [BEATS*LANES-1:0] mask_n;
  } slot_s;

  typedef struct packed {
    slot_s [HOST_PIPE_DEPTH-1:0] pipe;
    logic link_clk;
    logic k_edge;
    logic load_n;
    logic rw;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] bwe_n;
    logic [DATA_W-1:0] dq_o;
    logic dq_oe;
    logic [DATA_W-1:0] rd_lo;
    logic rd_valid;
    logic [BEATS*DATA_W-1:0] rd_data;
  } state_s;

  state_s s_ff;
  state_s nxt_s;
  logic tick;
  logic turn_block;

  // Ticks fall mid-beat, so link outputs are steady at the rising edge
  assign tick = s_ff.link_clk;
  // [R23] A write waits until read data has left the bus
  assign turn_block = req_write && (s_ff.pipe[0].op == OP_READ || s_ff.pipe[1].op == OP_READ);
  // [R3] One command per K beat; the only forced gap holds back a write on the K beat right after a read
  assign req_ready = tick && !s_ff.k_edge && !turn_block;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    nxt_s = s_ff;
    nxt_s.link_clk = !s_ff.link_clk;
    nxt_s.rd_valid = 1'b0;
    if (tick) begin
      nxt_s.k_edge = !s_ff.k_edge;
      nxt_s.pipe[HOST_PIPE_DEPTH-1:1] = s_ff.pipe[HOST_PIPE_DEPTH-2:0];
      nxt_s.pipe[0] = '0;
      nxt_s.load_n = 1'b1;
      if (req_valid && req_ready) begin
        nxt_s.pipe[0].op = req_write ? OP_WRITE : OP_READ;
        nxt_s.pipe[0].wdata = req_wdata;
        nxt_s.pipe[0].mask_n = req_mask_n;
        nxt_s.load_n = 1'b0;
        nxt_s.rw = !req_write;
        nxt_s.addr = req_addr;
      end
      // [R9] First write beat presented for the next K edge
      // [R11] Lane enables travel with their own beat
      nxt_s.dq_oe = 1'b0;
      nxt_s.bwe_n = '1;
      if (s_ff.pipe[HOST_WR1_AGE].op == OP_WRITE) begin
        nxt_s.dq_o = s_ff.pipe[HOST_WR1_AGE].wdata[DATA_W-1:0];
        nxt_s.bwe_n = s_ff.pipe[HOST_WR1_AGE].mask_n[LANES-1:0];
        nxt_s.dq_oe = 1'b1;
      end else if (s_ff.pipe[HOST_WR2_AGE].op == OP_WRITE) begin
        nxt_s.dq_o = s_ff.pipe[HOST_WR2_AGE].wdata[BEATS*DATA_W-1:DATA_W];
        nxt_s.bwe_n = s_ff.pipe[HOST_WR2_AGE].mask_n[BEATS*LANES-1:LANES];
        nxt_s.dq_oe = 1'b1;
      end
      // [R17] Output clocks not delayed; mid-beat sampling leaves margin
      if (s_ff.pipe[HOST_RD1_AGE].op == OP_READ) begin
        nxt_s.rd_lo = lnk.dq;
      end
      if (s_ff.pipe[HOST_RD2_AGE].op == OP_READ) begin
        nxt_s.rd_data = {lnk.dq, s_ff.rd_lo};
        nxt_s.rd_valid = 1'b1;
      end
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign lnk.link_clk = s_ff.link_clk;
  assign lnk.k_edge = s_ff.k_edge;
  assign lnk.load_command_n = s_ff.load_n;
  assign lnk.read_write = s_ff.rw;
  assign lnk.sync_address_inputs = s_ff.addr;
  assign lnk.byte_write_enable_n = s_ff.bwe_n;
  assign lnk.dq_host_o = s_ff.dq_o;
  assign lnk.dq_host_oe = s_ff.dq_oe;
  assign rd_valid = s_ff.rd_valid;
  assign rd_data = s_ff.rd_data;

endmodule : burst2_sram_controller

// File: sim/burst2_sram_sva.sv
// Concurrent checks on the burst-of-two SRAM link wires.
// Assumes link_clk comes from the controller end and both ends share reset_n.
`timescale 1ns/1ps
module burst2_sram_sva (
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic k_edge,
  input wire logic load_command_n,
  input wire logic read_write,
  input wire logic dq_host_oe,
  input wire logic dq_dev_oe
);
  // ************************************************************
  // Link timing checks
  // ************************************************************
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!reset_n);

  // Commands count only on K beats; K-bar beats never carry one
  wire rd_cmd = k_edge && !load_command_n && read_write;
  wire wr_cmd = k_edge && !load_command_n && !read_write;

  sequence rd_beats_s;
    dq_dev_oe ##1 dq_dev_oe;
  endsequence
  sequence wr_beats_s;
    dq_host_oe ##1 dq_host_oe;
  endsequence
  sequence rd_then_idle_s;
    rd_cmd ##2 !rd_cmd;
  endsequence

  a_rd_two_beats: assert property (rd_cmd |-> ##4 rd_beats_s)
    else $error("read burst did not drive two beats");
  a_dev_oe_cause: assert property (dq_dev_oe |-> $past(rd_cmd, 4) || $past(rd_cmd, 5))
    else $error("device drove the bus without a read");
  a_rd_release: assert property (rd_then_idle_s |-> ##4 !dq_dev_oe)
    else $error("device kept driving after the read burst");
  a_load_ignored: assert property (k_edge && load_command_n |-> ##4 !dq_dev_oe)
    else $error("deselected cycle produced read data");
  a_wr_late_beats: assert property (wr_cmd |-> ##2 wr_beats_s)
    else $error("write data beats not presented late");
  a_host_oe_cause: assert property (dq_host_oe |-> $past(wr_cmd, 2) || $past(wr_cmd, 3))
    else $error("controller drove the bus without a write");
  a_bus_no_clash: assert property (!(dq_dev_oe && dq_host_oe))
    else $error("both ends drive the data bus");
  a_k_alternate: assert property (k_edge |=> !k_edge)
    else $error("K beat not followed by K-bar beat");
endmodule : burst2_sram_sva

// File: sim/ddr_burst2_common_io_sram_port_tb_top.sv
// Self-checking bench: controller and SRAM port joined by the link interface.
// Assumes both ends share reset_n and the controller makes link_clk from sys_clk.
`timescale 1ns/1ps
module ddr_burst2_common_io_sram_port_tb_top;
  import burst2_sram_pkg::*;
  localparam int DW = LANES_DEF * LANE_W_DEF;
  localparam int WW = BEATS * DW;
  localparam int MW = BEATS * LANES_DEF;
  localparam int NLW = 4;
  localparam int NDW = LANES_DEF * NLW;
  localparam int NWW = BEATS * NDW;
  logic sys_clk = 1'b0;
  // Asserted by a real edge in the first process, so the async resets see it
  logic reset_n = 1'b1;
  logic n_req_ready;
  logic n_rd_valid;
  logic [NWW-1:0] n_rd_data;
  logic [NWW-1:0] n_mem [1<<ADDR_W_DEF] = '{default: '0};
  logic [NWW-1:0] n_exp_q [$];
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [ADDR_W_DEF-1:0] req_addr = '0;
  logic [WW-1:0] req_wdata = '0;
  logic [MW-1:0] req_mask_n = '1;
  logic out_clk_tied = 1'b0;
  logic dll_disable_n = 1'b1;
  logic imp_compare_up = 1'b0;
  logic req_ready;
  logic rd_valid;
  logic dll_enabled;
  logic launch_from_k;
  logic [WW-1:0] rd_data;
  logic [IMP_CODE_W-1:0] imp_code;
  logic [DW-1:0] mem [1<<ADDR_W_DEF] = '{default: '0};
  logic [WW-1:0] exp_q [$];
  int err_count = 0;
  int n_tests = 0;

  always #20 sys_clk = ~sys_clk;

  burst2_sram_link lnk ();
  burst2_sram_controller burst2_sram_controller_inst (.sys_clk(sys_clk), .reset_n(reset_n), .lnk(lnk),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_mask_n(req_mask_n), .rd_valid(rd_valid), .rd_data(rd_data));
  // Short impedance period keeps the stepping visible in a short run
  ddr_burst2_common_io_sram_port #(.IMP_PERIOD(8)) ddr_burst2_common_io_sram_port_inst (.reset_n(reset_n),
    .lnk(lnk), .out_clk_tied(out_clk_tied), .dll_disable_n(dll_disable_n), .imp_compare_up(imp_compare_up),
    .dll_enabled(dll_enabled), .launch_from_k(launch_from_k), .imp_code(imp_code));
  burst2_sram_sva burst2_sram_sva_inst (.reset_n(reset_n), .link_clk(lnk.link_clk), .k_edge(lnk.k_edge),
    .load_command_n(lnk.load_command_n), .read_write(lnk.read_write), .dq_host_oe(lnk.dq_host_oe),
    .dq_dev_oe(lnk.dq_dev_oe));

  // Nybble-lane pair with the hidden burst LSB, fed by the same requests
  burst2_sram_link #(.LANE_W(NLW)) n_lnk ();
  burst2_sram_controller #(.LANE_W(NLW)) burst2_sram_controller_nyb_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .lnk(n_lnk), .req_valid(req_valid), .req_ready(n_req_ready), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata[NWW-1:0]), .req_mask_n(req_mask_n), .rd_valid(n_rd_valid), .rd_data(n_rd_data));
  ddr_burst2_common_io_sram_port #(.LANE_W(NLW), .LSB_PIN(1'b0), .IMP_PERIOD(8))
    ddr_burst2_common_io_sram_port_nyb_inst (.reset_n(reset_n), .lnk(n_lnk), .out_clk_tied(out_clk_tied),
    .dll_disable_n(dll_disable_n), .imp_compare_up(imp_compare_up), .dll_enabled(), .launch_from_k(),
    .imp_code());
  burst2_sram_sva burst2_sram_sva_nyb_inst (.reset_n(reset_n), .link_clk(n_lnk.link_clk),
    .k_edge(n_lnk.k_edge), .load_command_n(n_lnk.load_command_n), .read_write(n_lnk.read_write),
    .dq_host_oe(n_lnk.dq_host_oe), .dq_dev_oe(n_lnk.dq_dev_oe));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input logic [WW-1:0] got, input logic [WW-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // Request is held until req_ready; the note of the answer is made when it is taken
  task automatic req(input logic w, input logic [ADDR_W_DEF-1:0] a, input logic [WW-1:0] d, input logic [MW-1:0] m);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      req_valid = 1'b1;
      req_write = w;
      req_addr = a;
      req_wdata = d;
      req_mask_n = m;
      #1;
      n++;
    end while (req_ready !== 1'b1 && n < 64);
    check(WW'(n < 64), WW'(1));
    check(WW'(n_req_ready), WW'(1));
    if (!w) exp_q.push_back({mem[a ^ ADDR_W_DEF'(1)], mem[a]});
    if (!w) n_exp_q.push_back(n_mem[a]);
    for (int b = 0; b < BEATS; b++) begin
      for (int l = 0; l < LANES_DEF; l++) begin
        if (w && !m[b*LANES_DEF+l]) mem[a ^ ADDR_W_DEF'(b)][l*LANE_W_DEF +: LANE_W_DEF] =
          d[b*DW + l*LANE_W_DEF +: LANE_W_DEF];
        if (w && !m[b*LANES_DEF+l]) n_mem[a][b*NDW + l*NLW +: NLW] = d[b*NDW + l*NLW +: NLW];
      end
    end
    @(posedge sys_clk);
  endtask : req

  task automatic idle(input int c);
    @(negedge sys_clk);
    req_valid = 1'b0;
    repeat (c) @(negedge sys_clk);
  endtask : idle

  // Skips the first change, which may still follow the old comparator level
  task automatic imp_step(input logic up);
    logic [IMP_CODE_W-1:0] v;
    int n;
    v = imp_code;
    n = 0;
    while (imp_code === v && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    v = imp_code;
    n = 0;
    while (imp_code === v && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    check(WW'(n), WW'(16));
    check(WW'(imp_code), WW'(up ? IMP_CODE_W'(v + 1) : IMP_CODE_W'(v - 1)));
  endtask : imp_step

  // ************************************************************
  // Read result watcher and main sequence
  // ************************************************************
  always @(negedge sys_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_count++;
        $display("unexpected read at %0t: got %h expected %h", $time, rd_data, 0);
      end else begin
        check(rd_data, exp_q.pop_front());
      end
    end
    if (n_rd_valid === 1'b1) begin
      if (n_exp_q.size() == 0) begin
        err_count++;
        $display("unexpected nybble read at %0t: got %h expected %h", $time, n_rd_data, 0);
      end else begin
        check(WW'(n_rd_data), WW'(n_exp_q.pop_front()));
      end
    end
  end

  initial begin
    void'($urandom(32'h6cd23453));
    @(negedge sys_clk);
    reset_n = 1'b0;
    repeat (10) @(negedge sys_clk);
    check(WW'({dll_enabled, launch_from_k, imp_code, lnk.dq_dev_oe, rd_valid}), '0);
    repeat (10) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (40) @(negedge sys_clk);
    check(WW'(imp_code), '0);
    imp_compare_up = 1'b1;
    imp_step(1'b1);
    imp_step(1'b1);
    imp_compare_up = 1'b0;
    imp_step(1'b0);
    dll_disable_n = 1'b0;
    out_clk_tied = 1'b1;
    repeat (8) @(negedge sys_clk);
    check(WW'({dll_enabled, launch_from_k}), WW'(2'b01));
    dll_disable_n = 1'b1;
    for (int r = 0; r < 4; r++) begin
      out_clk_tied = r[0];
      imp_compare_up = 1'($urandom);
      repeat (8) @(negedge sys_clk);
      check(WW'({dll_enabled, launch_from_k}), WW'({1'b1, r[0]}));
      for (int i = 0; i < 16; i++) begin
        req(1'b1, ADDR_W_DEF'($urandom), WW'({$urandom, $urandom}), r == 0 ? '0 : MW'($urandom));
      end
      idle(16);
      for (int i = 0; i < 16; i++) begin
        req(1'b0, ADDR_W_DEF'($urandom), '0, '1);
      end
      idle(16);
    end
    idle(30);
    check(WW'(exp_q.size()), '0);
    check(WW'(n_exp_q.size()), '0);
    stop_test();
  end

  initial begin
    #800000;
    err_count++;
    $display("unexpected timeout at %0t: got %h expected %h", $time, 0, 1);
    stop_test();
  end
endmodule : ddr_burst2_common_io_sram_port_tb_top
